// [ccpp_pkg.sv]
// package for the compare/pwm output unit: register map, fields, modes, carriers
// assumes an apb master on clk_sys and external timers feeding the unit
// Function
// - compare stops when system clock sleeps
// - compare event when value equals timer
// - pulse modes high only during match
// - toggle modes invert output each match
// - 1001 clears, 1000 sets on match
// - outputs routed internally and to pin
// - ten-bit pwm from selected timer
// - period is (pr+1)*4*tosc*prescale
// - period match clears, sets, latches duty
// - postscaler never affects pwm period
// - right aligned duty from high[1:0]
// - left aligned duty from low[7:6]
// - duty latch updates only at period
// - time base extends timer by two bits
// - output low when base equals duty
// - too-wide pulse leaves output unchanged
// - ratio is duty over 4(pr+1)
// - full ten bits only at pr 255
// - timer select picks one of four
// - control zero releases pin
// - mode 11xx selects pwm first
// - clear-on-match mode presets output high
package ccpp_pkg;
  // -------------------------------------------------------------------
  // register byte offsets
  // -------------------------------------------------------------------
  localparam logic [7:0] CCPP_OFF_CTRL = 8'h00; // unit_control_register
  localparam logic [7:0] CCPP_OFF_VALL = 8'h04; // match_value_low
  localparam logic [7:0] CCPP_OFF_VALH = 8'h08; // match_value_high
  localparam logic [7:0] CCPP_OFF_TSEL = 8'h0C; // pwm_timer_select
  // -------------------------------------------------------------------
  // field positions and reset values
  // -------------------------------------------------------------------
  localparam int CCPP_BIT_EN = 7;
  localparam int CCPP_BIT_OUT = 5;
  localparam int CCPP_BIT_FMT = 4;
  localparam logic [7:0] CCPP_RST_CTRL = 8'h00;
  localparam logic [7:0] CCPP_RST_VAL = 8'h00;
  localparam logic [1:0] CCPP_RST_TSEL = 2'h0;
  localparam logic [7:0] CCPP_CTRL_WMASK = 8'h9F; // out bit read only, bit 6 unimplemented
  // -------------------------------------------------------------------
  // mode codes
  // -------------------------------------------------------------------
  typedef enum logic [3:0] {
    CCPP_M_OFF = 4'b0000,
    CCPP_M_TOGCLR = 4'b0001,
    CCPP_M_TOG = 4'b0010,
    CCPP_M_SET = 4'b1000,
    CCPP_M_CLR = 4'b1001,
    CCPP_M_PULSE = 4'b1010,
    CCPP_M_PULCLR = 4'b1011
  } ccpp_mode_e;
  // timing: pwm timer ticks once per four system clocks
  localparam int CCPP_CLK_PER_TICK = 4;
  localparam logic [1:0] CCPP_PHASE_LAST = 2'(CCPP_CLK_PER_TICK - 1);
  // -------------------------------------------------------------------
  // carriers
  // -------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] count;    // pwm_base_timer value
    logic [7:0] period;   // period_register value
    logic [1:0] prescLow; // two low prescaler bits
    logic oneToOne;       // timer_prescale_field is 1:1
    logic tick;           // one-cycle increment strobe
  } ccpp_timer_s;
  typedef struct packed {
    logic compareOut; // compare/pwm result level
    logic compareEvt; // one-cycle match event
    logic timerClear; // wide timer reset request
    logic pinDrive;   // unit owns the pin
  } ccpp_out_s;
endpackage

// [ccpp_pwm_core.sv]
// standard pwm engine: period match, duty latch, ten-bit time base compare
// assumes timer inputs are synchronous to clk_sys
`timescale 1ns/10ps
module ccpp_pwm_core (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic pwmOn,
  input wire ccpp_pkg::ccpp_timer_s tmr,
  input wire logic [9:0] dutyIn,
  output logic pwmOut
);
  import ccpp_pkg::*;

  logic [1:0] phase_reg;   // system clock phase inside a tick
  logic [9:0] dutyLatch_reg; // double-buffered duty
  logic pwm_reg;
  logic periodEnd;
  logic [9:0] timeBase;
  logic [9:0] baseNext; // time base one clock ahead
  logic clrHit;         // time base reaches the latched duty

  // -------------------------------------------------------------------
  // time base
  // -------------------------------------------------------------------
  // phase resyncs on each tick so low bits line up with the timer
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= 2'b00;
    end else if (tmr.tick) begin
      phase_reg <= 2'b00;
    end else if (phase_reg != CCPP_PHASE_LAST) begin
      phase_reg <= phase_reg + 2'b01;
    end
  end

  // low bits from clock phase at 1:1, else from prescaler
  assign timeBase = {tmr.count, tmr.oneToOne ? phase_reg : tmr.prescLow};
  // postscaler plays no part here
  assign periodEnd = tmr.tick && (tmr.count == tmr.period);
  // at 1:1 look one clock ahead so the registered fall lands on the match count;
  // with a prescaler each count spans several clocks and the fall trails by one
  assign baseNext = timeBase + 10'h001;
  assign clrHit = (tmr.oneToOne ? baseNext : timeBase) == dutyLatch_reg;

  // -------------------------------------------------------------------
  // duty latch and output
  // -------------------------------------------------------------------
  // latch only at period end so mid-period writes cannot glitch
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dutyLatch_reg <= 10'h000;
    end else if (periodEnd) begin
      dutyLatch_reg <= dutyIn;
    end
  end

  // set at period start unless duty is zero; clear on base match
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pwm_reg <= 1'b0;
    end else if (!pwmOn) begin
      pwm_reg <= 1'b0;
    end else if (periodEnd) begin
      pwm_reg <= (dutyIn != 10'h000);
    end else if (clrHit) begin
      pwm_reg <= 1'b0;
    end
    // a duty beyond the period never matches, so level holds
  end

  assign pwmOut = pwm_reg;

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  property p_latch_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      !periodEnd |=> dutyLatch_reg == $past(dutyLatch_reg);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("duty latch moved mid period");

  property p_period_set;
    @(posedge clk_sys) disable iff (!rst_n)
      pwmOn && periodEnd && dutyIn != 10'h000 |=> pwm_reg;
  endproperty
  a_period_set: assert property (p_period_set) else $error("pwm not set at period");

  property p_base_clear;
    @(posedge clk_sys) disable iff (!rst_n)
      pwmOn && !periodEnd && clrHit |=> !pwm_reg;
  endproperty
  a_base_clear: assert property (p_base_clear) else $error("pwm not cleared on match");

  c_period: cover property (@(posedge clk_sys) disable iff (!rst_n) periodEnd && pwmOn);
endmodule

// [ccpp_unit.sv]
// top of the compare/pwm output unit with its apb register slave
// assumes wide timer, base timers and prescaler live outside on clk_sys
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
module ccpp_unit (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] wideTimer,
  input wire ccpp_pkg::ccpp_timer_s baseTimer0,
  input wire ccpp_pkg::ccpp_timer_s baseTimer1,
  input wire ccpp_pkg::ccpp_timer_s baseTimer2,
  input wire ccpp_pkg::ccpp_timer_s baseTimer3,
  output ccpp_pkg::ccpp_out_s unitOut,
  output logic pinOut,
  output logic pinOe_n
);
  import ccpp_pkg::*;

  // -------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------
  logic [7:0] ctrl_reg;   // unit_control_register (out bit unused here)
  logic [7:0] valLow_reg; // match_value_low
  logic [7:0] valHigh_reg; // match_value_high
  logic [1:0] tsel_reg;   // pwm_timer_select
  logic cmpOut_reg;       // compare output latch
  logic cmpEvt_reg;       // registered match event
  logic clrReq_reg;       // wide timer clear request
  logic [3:0] prevMode_reg; // mode seen last cycle
  logic [31:0] prdata_reg;
  logic wrEn;
  logic rdEn;
  logic mapped;
  logic [3:0] mode;
  logic enabled;
  logic pwmMode;
  logic match;
  logic matchPrev_reg;    // match level seen last cycle
  logic matchRise;        // first cycle of a match
  logic [9:0] duty;
  logic pwmOut;
  ccpp_timer_s selTimer;

  assign mode = ctrl_reg[3:0];
  assign enabled = ctrl_reg[CCPP_BIT_EN];

  // -------------------------------------------------------------------
  // decode helpers
  // -------------------------------------------------------------------
  // pwm has priority over every compare code
  function automatic logic isPwm(input logic [3:0] m);
    isPwm = (m[3:2] == 2'b11);
  endfunction

  // mode owns the pin; pulse/trigger codes leave the pin alone
  function automatic logic drivesPin(input logic [3:0] m);
    drivesPin = isPwm(m) || m == CCPP_M_TOGCLR || m == CCPP_M_TOG
      || m == CCPP_M_SET || m == CCPP_M_CLR;
  endfunction

  // the compare codes proper; capture codes raise no event
  function automatic logic isCompare(input logic [3:0] m);
    isCompare = m == CCPP_M_TOGCLR || m == CCPP_M_TOG || m == CCPP_M_SET
      || m == CCPP_M_CLR || m == CCPP_M_PULSE || m == CCPP_M_PULCLR;
  endfunction

  assign pwmMode = enabled && isPwm(mode);

  // -------------------------------------------------------------------
  // apb slave: zero wait states
  // -------------------------------------------------------------------
  assign wrEn = psel && penable && pwrite;
  assign rdEn = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign mapped = (paddr == CCPP_OFF_CTRL) || (paddr == CCPP_OFF_VALL)
    || (paddr == CCPP_OFF_VALH) || (paddr == CCPP_OFF_TSEL);
  assign pslverr = psel && penable && !mapped;

  // control register write
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= CCPP_RST_CTRL;
    end else if (wrEn && paddr == CCPP_OFF_CTRL) begin
      ctrl_reg <= pwdata[7:0] & CCPP_CTRL_WMASK;
    end
  end

  // value pair and timer select writes, accepted any time
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      valLow_reg <= CCPP_RST_VAL;
      valHigh_reg <= CCPP_RST_VAL;
      tsel_reg <= CCPP_RST_TSEL;
    end else if (wrEn) begin
      if (paddr == CCPP_OFF_VALL) begin
        valLow_reg <= pwdata[7:0];
      end else if (paddr == CCPP_OFF_VALH) begin
        valHigh_reg <= pwdata[7:0];
      end else if (paddr == CCPP_OFF_TSEL) begin
        tsel_reg <= pwdata[1:0];
      end
    end
  end

  // read data captured in setup phase, stable through access
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata_reg <= 32'h0000_0000;
    end else if (rdEn) begin
      if (paddr == CCPP_OFF_CTRL) begin
        prdata_reg <= {24'h00_0000, ctrl_reg[7:6], unitOut.compareOut, ctrl_reg[4:0]};
      end else if (paddr == CCPP_OFF_VALL) begin
        prdata_reg <= {24'h00_0000, valLow_reg};
      end else if (paddr == CCPP_OFF_VALH) begin
        prdata_reg <= {24'h00_0000, valHigh_reg};
      end else if (paddr == CCPP_OFF_TSEL) begin
        prdata_reg <= {30'h0000_0000, tsel_reg};
      end else begin
        prdata_reg <= 32'h0000_0000;
      end
    end
  end
  assign prdata = prdata_reg;

  // -------------------------------------------------------------------
  // compare path
  // -------------------------------------------------------------------
  // all compare logic runs on clk_sys; no clock means no compare
  assign match = ({valHigh_reg, valLow_reg} == wideTimer);
  // the timer holds a value for several clocks, so edge actions use the rise
  assign matchRise = match && !matchPrev_reg;

  // output latch per mode; pulse modes follow the match level
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmpOut_reg <= 1'b0;
    end else if (!enabled || mode == CCPP_M_OFF) begin
      cmpOut_reg <= 1'b0; // cleared control forces latch low
    end else if (!isPwm(mode)) begin
      if (mode != prevMode_reg && (mode == CCPP_M_CLR || mode == CCPP_M_SET)) begin
        cmpOut_reg <= 1'b1; // preset on mode entry
      end else if (mode == CCPP_M_PULSE || mode == CCPP_M_PULCLR) begin
        cmpOut_reg <= match;
      end else if (matchRise && (mode == CCPP_M_TOG || mode == CCPP_M_TOGCLR)) begin
        cmpOut_reg <= !cmpOut_reg;
      end else if (matchRise && mode == CCPP_M_CLR) begin
        cmpOut_reg <= 1'b0;
      end else if (matchRise && mode == CCPP_M_SET) begin
        cmpOut_reg <= 1'b1;
      end
    end
  end

  // event and clear request, one cycle per rising match
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmpEvt_reg <= 1'b0;
      clrReq_reg <= 1'b0;
      prevMode_reg <= 4'h0;
      matchPrev_reg <= 1'b0;
    end else begin
      prevMode_reg <= mode;
      matchPrev_reg <= match;
      cmpEvt_reg <= enabled && isCompare(mode) && matchRise;
      clrReq_reg <= enabled && matchRise && (mode == CCPP_M_PULCLR || mode == CCPP_M_TOGCLR);
    end
  end

  // -------------------------------------------------------------------
  // pwm path
  // -------------------------------------------------------------------
  // timer chosen independently per unit
  always_comb begin
    if (tsel_reg == 2'd0) begin
      selTimer = baseTimer0;
    end else if (tsel_reg == 2'd1) begin
      selTimer = baseTimer1;
    end else if (tsel_reg == 2'd2) begin
      selTimer = baseTimer2;
    end else begin
      selTimer = baseTimer3;
    end
  end

  // alignment picks bits; unused bits never reach the compare
  always_comb begin
    if (ctrl_reg[CCPP_BIT_FMT]) begin
      duty = {valHigh_reg, valLow_reg[7:6]};
    end else begin
      duty = {valHigh_reg[1:0], valLow_reg};
    end
  end

  // ratio duty/(4(pr+1)) and resolution follow from this engine
  ccpp_pwm_core u_pwm (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pwmOn(pwmMode),
    .tmr(selTimer),
    .dutyIn(duty),
    .pwmOut(pwmOut)
  );

  // -------------------------------------------------------------------
  // outputs to other peripherals and the pin
  // -------------------------------------------------------------------
  // same result feeds internal consumers and the pin
  // one driver for the whole carrier; zero control releases the pin
  assign unitOut = '{compareOut: pwmMode ? pwmOut : cmpOut_reg, compareEvt: cmpEvt_reg,
    timerClear: clrReq_reg, pinDrive: enabled && drivesPin(mode)};
  assign pinOut = unitOut.compareOut;
  assign pinOe_n = !unitOut.pinDrive;

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  property p_pulse;
    @(posedge clk_sys) disable iff (!rst_n)
      enabled && mode == CCPP_M_PULSE && $stable(mode) |=> cmpOut_reg == $past(match);
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse output not equal to match");

  property p_toggle;
    @(posedge clk_sys) disable iff (!rst_n)
      enabled && mode == CCPP_M_TOG && matchRise |=> cmpOut_reg != $past(cmpOut_reg);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle missed");

  property p_clr;
    @(posedge clk_sys) disable iff (!rst_n)
      enabled && mode == CCPP_M_CLR && prevMode_reg == CCPP_M_CLR && match |=> !cmpOut_reg;
  endproperty
  a_clr: assert property (p_clr) else $error("clear on match missed");

  property p_entry;
    @(posedge clk_sys) disable iff (!rst_n)
      enabled && mode == CCPP_M_CLR && prevMode_reg != CCPP_M_CLR |=> cmpOut_reg;
  endproperty
  a_entry: assert property (p_entry) else $error("clear mode not preset high");

  property p_release;
    @(posedge clk_sys) disable iff (!rst_n)
      ctrl_reg == 8'h00 |-> pinOe_n ##1 !unitOut.compareOut;
  endproperty
  a_release: assert property (p_release) else $error("pin held after control cleared");

  property p_pwm_pri;
    @(posedge clk_sys) disable iff (!rst_n)
      enabled && mode[3:2] == 2'b11 |-> unitOut.compareOut == pwmOut && !pinOe_n;
  endproperty
  a_pwm_pri: assert property (p_pwm_pri) else $error("pwm not selected for 11xx");

  c_toggle: cover property (@(posedge clk_sys) disable iff (!rst_n)
    enabled && mode == CCPP_M_TOG && match);
  c_pwm: cover property (@(posedge clk_sys) disable iff (!rst_n) pwmMode && pwmOut);
  c_write: cover property (@(posedge clk_sys) disable iff (!rst_n) wrEn && paddr == CCPP_OFF_VALH);
endmodule

// [ccpp_timer_model.sv]
// far-side model: one free-running wide timer and four 8-bit pwm base timers
// assumes the unit under test runs on the same clk_sys and rst_n
`timescale 1ns/10ps
module ccpp_timer_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic restart,
  input wire logic timerClear,
  input wire logic [7:0] prBase,
  output logic [15:0] wideTimer,
  output ccpp_pkg::ccpp_timer_s baseTimer0,
  output ccpp_pkg::ccpp_timer_s baseTimer1,
  output ccpp_pkg::ccpp_timer_s baseTimer2,
  output ccpp_pkg::ccpp_timer_s baseTimer3
);
  import ccpp_pkg::*;
  // ----------------------------------------
  // shared fosc/4 tick
  // ----------------------------------------
  logic [1:0] phaseReg; // system clock phase
  logic tick; // one tick per four clocks
  ccpp_timer_s tmrArr [4]; // per-timer carrier
  assign tick = (phaseReg == 2'h3);
  // phase counter, free running so every timer shares one tick
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phaseReg <= 2'h0;
    end else begin
      phaseReg <= phaseReg + 2'h1;
    end
  end
  // wide timer, cleared by the bench or by the unit's clear request
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wideTimer <= 16'h0000;
    end else if (restart || timerClear) begin
      wideTimer <= 16'h0000;
    end else if (tick) begin
      wideTimer <= wideTimer + 16'h0001;
    end
  end
  // ----------------------------------------
  // base timers: timer k reloads at prBase >> k
  // ----------------------------------------
  for (genvar k = 0; k < 4; k++) begin : g_tmr
    logic [7:0] cntReg; // counter value
    // 1:1 prescale, so low bits come from the unit's own phase
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        cntReg <= 8'h00;
      end else if (tick) begin
        cntReg <= (cntReg == (prBase >> k)) ? 8'h00 : cntReg + 8'h01;
      end
    end
    assign tmrArr[k] = '{cntReg, prBase >> k, 2'h0, 1'b1, tick};
  end
  assign baseTimer0 = tmrArr[0];
  assign baseTimer1 = tmrArr[1];
  assign baseTimer2 = tmrArr[2];
  assign baseTimer3 = tmrArr[3];
endmodule

// [ccpp_unit_tb.sv]
// self-checking bench for the compare/pwm unit: registers, compare modes, pwm
// assumes ccpp_pkg and ccpp_timer_model are compiled before it
`timescale 1ns/10ps
module ccpp_unit_tb;
  import ccpp_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic restart = 1'b0; // wide timer restart
  logic [7:0] prBase = 8'h0F; // base timer reload
  logic [15:0] wideTimer;
  ccpp_timer_s bt0, bt1, bt2, bt3;
  ccpp_out_s unitOut;
  logic pinOut;
  logic pinOe_n;
  int fail_count = 0;
  int checks_done = 0;
  // 25 mhz clock
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  ccpp_unit dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wideTimer(wideTimer), .baseTimer0(bt0), .baseTimer1(bt1),
    .baseTimer2(bt2), .baseTimer3(bt3), .unitOut(unitOut), .pinOut(pinOut),
    .pinOe_n(pinOe_n));
  ccpp_timer_model tmr (.clk_sys(clk_sys), .rst_n(rst_n), .restart(restart),
    .timerClear(unitOut.timerClear), .prBase(prBase), .wideTimer(wideTimer),
    .baseTimer0(bt0), .baseTimer1(bt1), .baseTimer2(bt2), .baseTimer3(bt3));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // one apb transfer, request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h00_0000, wd};
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask
  task automatic rd_check(input logic [7:0] a, input logic [7:0] exp, input logic expErr);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 8'h00, rd, err);
    check(rd, {24'h00_0000, exp}, "read data");
    check(32'(err), 32'(expErr), "slave error");
  endtask
  // let write effects land before looking
  task automatic settle();
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_regs();
    settle();
    check(32'(pinOe_n), 32'h0000_0001, "pin released at reset");
    rd_check(CCPP_OFF_CTRL, CCPP_RST_CTRL, 1'b0);
    rd_check(CCPP_OFF_VALL, CCPP_RST_VAL, 1'b0);
    rd_check(CCPP_OFF_VALH, CCPP_RST_VAL, 1'b0);
    rd_check(CCPP_OFF_TSEL, {6'h00, CCPP_RST_TSEL}, 1'b0);
    wr(8'h10, 8'hFF); // unmapped write is dropped
    rd_check(8'h10, 8'h00, 1'b1);
    wr(CCPP_OFF_VALL, 8'hA5);
    rd_check(CCPP_OFF_VALL, 8'hA5, 1'b0);
    wr(CCPP_OFF_CTRL, 8'h60); // output bit read only, bit 6 unimplemented
    rd_check(CCPP_OFF_CTRL, 8'h00, 1'b0);
    $display("test regs done");
  endtask
  // compare against 0x0105, check event, level and pin use
  task automatic test_compare(input ccpp_mode_e mode);
    logic evt;
    int n;
    wr(CCPP_OFF_CTRL, 8'h00);
    settle();
    check(32'(unitOut.compareOut), 32'h0000_0000, "cleared latch");
    wr(CCPP_OFF_VALL, 8'h05);
    wr(CCPP_OFF_VALH, 8'h01);
    wr(CCPP_OFF_CTRL, {4'h8, mode});
    restart <= 1'b1;
    @(posedge clk_sys);
    restart <= 1'b0;
    settle();
    if (mode inside {CCPP_M_SET, CCPP_M_CLR}) begin
      check(32'(unitOut.compareOut), 32'h0000_0001, "preset high");
    end
    n = 0;
    while (wideTimer !== 16'h0105 && n < 2000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    evt = 1'b0;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      #1;
      evt |= unitOut.compareEvt;
      // level stands from the first edge; clear-timer pulse modes end early
      if (i == 0) begin
        check(32'(unitOut.compareOut), 32'(mode != CCPP_M_CLR), "level after match");
        check(32'(pinOut), 32'(unitOut.compareOut), "pin follows output");
      end
    end
    check(32'(evt), 32'h0000_0001, "match event");
    check(32'(pinOe_n), 32'(mode inside {CCPP_M_PULSE, CCPP_M_PULCLR}), "pin drive");
    if (mode inside {CCPP_M_PULSE, CCPP_M_PULCLR}) begin
      repeat (5) @(posedge clk_sys);
      #1;
      check(32'(unitOut.compareOut), 32'h0000_0000, "pulse ends");
    end
    $display("test compare mode %b done", mode);
  endtask
  // program duty, wait for latch, count high clocks over two periods
  task automatic test_pwm(input logic [1:0] sel, input logic fmt, input logic [9:0] duty,
                          input logic [3:0] mode);
    int per;
    int hi;
    per = 4 * (int'(prBase >> sel) + 1);
    hi = 0;
    wr(CCPP_OFF_TSEL, {6'h00, sel});
    wr(CCPP_OFF_CTRL, {3'h4, fmt, mode});
    if (fmt) begin
      wr(CCPP_OFF_VALH, duty[9:2]);
      wr(CCPP_OFF_VALL, {duty[1:0], 6'h3F});
    end else begin
      wr(CCPP_OFF_VALH, {6'h3F, duty[9:8]});
      wr(CCPP_OFF_VALL, duty[7:0]);
    end
    repeat (3 * per) @(posedge clk_sys);
    repeat (2 * per) begin
      @(posedge clk_sys);
      #1;
      hi += int'(unitOut.compareOut === 1'b1);
    end
    check(32'(hi), 32'(2 * ((int'(duty) < per) ? int'(duty) : per)), "high clocks");
    check(32'(pinOe_n), 32'h0000_0000, "pwm drives pin");
    $display("test pwm sel %0d duty %0d done", sel, duty);
  endtask
  // ----------------------------------------
  // verdict and main sequence
  // ----------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // hang guard, several times the expected run length
  initial begin
    #(40 * 60000);
    fail_count++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    test_regs();
    test_compare(CCPP_M_SET);
    test_compare(CCPP_M_CLR);
    test_compare(CCPP_M_TOG);
    test_compare(CCPP_M_TOGCLR);
    test_compare(CCPP_M_PULSE);
    test_compare(CCPP_M_PULCLR);
    test_pwm(2'h0, 1'b0, 10'h014, 4'hC);
    test_pwm(2'h1, 1'b1, 10'h01F, 4'hD);
    test_pwm(2'h2, 1'b0, 10'h064, 4'hE);
    test_pwm(2'h3, 1'b1, 10'h000, 4'hF);
    wr(CCPP_OFF_CTRL, 8'h00);
    settle();
    check(32'(pinOe_n), 32'h0000_0001, "pin released");
    print_verdict();
  end
endmodule
